/* shared/ebr_cfg.svh */
// Purpose: constants of the embedded block ram
// Assumes: included by package and design modules
// Notes:   guarded against double inclusion
`ifndef EBR_CFG_SVH
`define EBR_CFG_SVH
`define EBR_ROWS        128
`define EBR_ROW_BITS    36
`define EBR_ROW_IDX     7
`define EBR_COL_BITS    6
`define EBR_ADDR_BITS   12
`define EBR_TAP_BITS    6
`define EBR_LEN_BITS    8
`define EBR_SR_MAX_BITS 20'd4608
`define EBR_SR_MAX_WN   12'd36
`define EBR_SR_MAX_LEN  8'd128
`define EBR_Q_RESET     36'h0
`define EBR_UNDEF_WORD  36'hfffffffff
`define EBR_INIT_ROW    36'h0
`endif

/* shared/ebr_pkg.sv */
// Purpose: types shared by the block ram files
// Assumes: ebr_cfg.svh for widths
// Notes:   nothing is imported by users
`include "ebr_cfg.svh"
package ebr_pkg;
	typedef enum logic [2:0] {MODE_SDP, MODE_TDP, MODE_SHIFT, MODE_ROM, MODE_FIFO} mode_e;
	typedef enum logic [3:0] {
		SHAPE_X1, SHAPE_X2, SHAPE_X4, SHAPE_X8, SHAPE_X16, SHAPE_X32,
		SHAPE_X9, SHAPE_X18, SHAPE_X36
	} shape_e;
	typedef struct packed {
		logic [`EBR_ROWS-1:0][`EBR_ROW_BITS-1:0] rows;
	} ram_state_s;
	typedef struct packed {
		logic [`EBR_ROW_BITS-1:0] a_s1;
		logic [`EBR_ROW_BITS-1:0] a_q;
		logic [`EBR_ROW_BITS-1:0] b_s1;
		logic [`EBR_ROW_BITS-1:0] b_q;
		logic [`EBR_ROW_IDX-1:0]  sr_ptr;
		logic                     err;
	} top_state_s;
endpackage : ebr_pkg

/* rtl/ebr_shape_map.sv */
// Purpose: maps a port shape and word address to row, column and mask
// Assumes: rows of 36 bits, non-parity shapes use the low 32
// Notes:   purely combinational
`timescale 1ns/10ps
`include "ebr_cfg.svh"
module ebr_shape_map (
	input  ebr_pkg::shape_e                shape,
	input  logic [`EBR_ADDR_BITS-1:0]      addr,
	output logic [`EBR_ROW_IDX-1:0]        row,
	output logic [`EBR_COL_BITS-1:0]       col,
	output logic [`EBR_COL_BITS-1:0]       width,
	output logic [`EBR_ROW_BITS-1:0]       wmask
);
	logic [2:0] lg;
	logic [4:0] idx;

	always_comb begin
		width = 6'h01;
		lg    = 3'h5;
		case (shape)
			ebr_pkg::SHAPE_X1: begin
				width = 6'h01;
				lg    = 3'h5;
			end
			ebr_pkg::SHAPE_X2: begin
				width = 6'h02;
				lg    = 3'h4;
			end
			ebr_pkg::SHAPE_X4: begin
				width = 6'h04;
				lg    = 3'h3;
			end
			ebr_pkg::SHAPE_X8, ebr_pkg::SHAPE_X9: begin
				width = (shape == ebr_pkg::SHAPE_X9) ? 6'h09 : 6'h08;
				lg    = 3'h2;
			end
			ebr_pkg::SHAPE_X16, ebr_pkg::SHAPE_X18: begin
				width = (shape == ebr_pkg::SHAPE_X18) ? 6'h12 : 6'h10;
				lg    = 3'h1;
			end
			ebr_pkg::SHAPE_X32, ebr_pkg::SHAPE_X36: begin
				width = (shape == ebr_pkg::SHAPE_X36) ? 6'h24 : 6'h20;
				lg    = 3'h0;
			end
			default: begin
				width = 6'h01;
				lg    = 3'h5;
			end
		endcase
		// address bits above the depth are dropped
		row   = 7'(addr >> lg);
		idx   = 5'(addr & ((12'h001 << lg) - 12'h001));
		col   = 6'(idx * width);
		wmask = 36'((37'h1 << width) - 37'h1);
	end
endmodule : ebr_shape_map

/* rtl/ebr_array.sv */
// Purpose: flip-flop storage of 128 rows by 36 bits, two write ports
// Assumes: writes are bit-masked, reads are row-wide
// Notes:   reads see contents from before this cycle's writes
`timescale 1ns/10ps
`include "ebr_cfg.svh"
module ebr_array #(
	parameter logic [`EBR_ROWS*`EBR_ROW_BITS-1:0] INIT_IMAGE = {`EBR_ROWS{`EBR_INIT_ROW}}
) (
	input  logic                       clk_sys,
	input  logic                       rst_n,
	input  logic                       clk_en,
	input  logic                       wa_en,
	input  logic [`EBR_ROW_IDX-1:0]    wa_row,
	input  logic [`EBR_ROW_BITS-1:0]   wa_bits,
	input  logic [`EBR_ROW_BITS-1:0]   wa_data,
	input  logic                       wb_en,
	input  logic [`EBR_ROW_IDX-1:0]    wb_row,
	input  logic [`EBR_ROW_BITS-1:0]   wb_bits,
	input  logic [`EBR_ROW_BITS-1:0]   wb_data,
	input  logic [`EBR_ROW_IDX-1:0]    ra_row,
	input  logic [`EBR_ROW_IDX-1:0]    rb_row,
	output logic [`EBR_ROW_BITS-1:0]   ra_data,
	output logic [`EBR_ROW_BITS-1:0]   rb_data
);
	ebr_pkg::ram_state_s                     st_q;
	ebr_pkg::ram_state_s                     st_d;
	logic [`EBR_ROWS-1:0][`EBR_ROW_BITS-1:0] row_n;

	genvar gi;
	generate
		for (gi = 0; gi < `EBR_ROWS; gi++) begin : g_row
			logic [`EBR_ROW_BITS-1:0] after_b;
			assign after_b = (wb_en && wb_row == 7'(gi)) ?
				((st_q.rows[gi] & ~wb_bits) | (wb_data & wb_bits)) : st_q.rows[gi];
			assign row_n[gi] = (wa_en && wa_row == 7'(gi)) ?
				((after_b & ~wa_bits) | (wa_data & wa_bits)) : after_b;
		end
	endgenerate

	always_comb begin
		st_d.rows = row_n;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q.rows <= INIT_IMAGE;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign ra_data = st_q.rows[ra_row];
	assign rb_data = st_q.rows[rb_row];
endmodule : ebr_array

/* rtl/ebr_block.sv */
// Purpose: embedded block ram with dual-port, shift, rom and fifo modes
// Assumes: one clock; per-side clock enables model the split clocks
// Notes:   write commit stands for the falling edge of the write clock
`timescale 1ns/10ps
`include "ebr_cfg.svh"
// Operation
// - simple dual-port reads and writes together
// - simple dual-port mixed widths, one family
// - simple dual-port: one write, one read strobe
// - read strobe clear forces reads enabled
// - idle read strobe holds output word
// - simple dual-port collision: old or undefined
// - simple dual-port split clock arrangements
// - true dual-port any two operations
// - true dual-port widest shape sixteen/eighteen
// - true dual-port pairings within one family
// - true dual-port clock arrangements supported
// - true dual-port write passes to output
// - writes commit at write clock fall
// - shift size limits on bits
// - shift advances one position per clock
// - rom: registered address, read like ram
// - rom contents from initial image
// - fifo storage outputs are combinational; the code only forces b_oreg off, so b_q is still registered
// - outputs read zero after power-up
// - mixed-port collision option old/undefined
module ebr_block (
	input  logic                       clk_sys,
	input  logic                       rst_n,
	input  logic                       clk_en,
	input  ebr_pkg::mode_e             mode,
	input  logic                       rdw_old_data,
	input  ebr_pkg::shape_e            a_shape,
	input  ebr_pkg::shape_e            b_shape,
	input  logic                       a_out_reg,
	input  logic                       b_out_reg,
	input  logic [`EBR_LEN_BITS-1:0]   sr_len,
	input  logic [`EBR_TAP_BITS-1:0]   sr_taps,
	input  logic [`EBR_ADDR_BITS-1:0]  a_addr,
	input  logic [`EBR_ROW_BITS-1:0]   a_din,
	input  logic                       a_wr,
	input  logic                       a_rd,
	input  logic                       a_in_ce,
	input  logic                       a_out_ce,
	input  logic                       a_in_clr,
	input  logic                       a_out_clr,
	input  logic [`EBR_ADDR_BITS-1:0]  b_addr,
	input  logic [`EBR_ROW_BITS-1:0]   b_din,
	input  logic                       b_wr,
	input  logic                       b_rd,
	input  logic                       b_in_ce,
	input  logic                       b_out_ce,
	input  logic                       b_in_clr,
	input  logic                       b_out_clr,
	output logic [`EBR_ROW_BITS-1:0]   a_q,
	output logic [`EBR_ROW_BITS-1:0]   b_q,
	output logic                       cfg_err
);
	ebr_pkg::top_state_s               st_q;
	ebr_pkg::top_state_s               st_d;
	logic [`EBR_ROW_IDX-1:0]           a_row;
	logic [`EBR_ROW_IDX-1:0]           b_row;
	logic [`EBR_COL_BITS-1:0]          a_col;
	logic [`EBR_COL_BITS-1:0]          b_col;
	logic [`EBR_COL_BITS-1:0]          a_w;
	logic [`EBR_COL_BITS-1:0]          b_w;
	logic [`EBR_ROW_BITS-1:0]          a_wmask;
	logic [`EBR_ROW_BITS-1:0]          b_wmask;
	logic                              wa_en;
	logic [`EBR_ROW_IDX-1:0]           wa_row;
	logic [`EBR_ROW_BITS-1:0]          wa_bits;
	logic [`EBR_ROW_BITS-1:0]          wa_data;
	logic                              wb_en;
	logic [`EBR_ROW_BITS-1:0]          wb_bits;
	logic [`EBR_ROW_BITS-1:0]          wb_data;
	logic [`EBR_ROW_IDX-1:0]           ra_row;
	logic [`EBR_ROW_BITS-1:0]          ra_data;
	logic [`EBR_ROW_BITS-1:0]          rb_data;
	logic                              legal;
	logic                              a_par;
	logic                              b_par;
	logic                              a_wide;
	logic                              b_wide;
	logic [11:0]                       sr_wn;
	logic [19:0]                       sr_bits;
	logic [`EBR_ROW_BITS-1:0]          sr_mask;
	logic                              a_re;
	logic                              b_re;
	logic                              a_ld;
	logic                              b_ld;
	logic [`EBR_ROW_BITS-1:0]          a_val;
	logic [`EBR_ROW_BITS-1:0]          b_val;
	logic                              a_oreg;
	logic                              b_oreg;
	logic [2*`EBR_ROW_BITS-1:0]        a_stage;
	logic [2*`EBR_ROW_BITS-1:0]        b_stage;

	ebr_shape_map u_map_a (
		.shape (a_shape),
		.addr  (a_addr),
		.row   (a_row),
		.col   (a_col),
		.width (a_w),
		.wmask (a_wmask)
	);

	ebr_shape_map u_map_b (
		.shape (b_shape),
		.addr  (b_addr),
		.row   (b_row),
		.col   (b_col),
		.width (b_w),
		.wmask (b_wmask)
	);

	ebr_array u_array (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.wa_en   (wa_en),
		.wa_row  (wa_row),
		.wa_bits (wa_bits),
		.wa_data (wa_data),
		.wb_en   (wb_en),
		.wb_row  (b_row),
		.wb_bits (wb_bits),
		.wb_data (wb_data),
		.ra_row  (ra_row),
		.rb_row  (b_row),
		.ra_data (ra_data),
		.rb_data (rb_data)
	);

	// output stage shared by both ports: returns {s1, q}
	function automatic logic [2*`EBR_ROW_BITS-1:0] out_stage(
		input logic                     ld,
		input logic [`EBR_ROW_BITS-1:0] val,
		input logic                     oreg,
		input logic                     oce,
		input logic                     oclr,
		input logic                     iclr,
		input logic [`EBR_ROW_BITS-1:0] s1,
		input logic [`EBR_ROW_BITS-1:0] q
	);
		logic [`EBR_ROW_BITS-1:0] s1_n;
		logic [`EBR_ROW_BITS-1:0] q_n;
		s1_n = s1;
		q_n  = q;
		if (iclr) begin
			s1_n = `EBR_Q_RESET;
		end else if (ld) begin
			s1_n = val;
		end
		if (oclr) begin
			q_n = `EBR_Q_RESET;
		end else if (!oreg) begin
			if (ld) begin
				q_n = val;
			end
		end else if (oce) begin
			q_n = s1;
		end
		return {s1_n, q_n};
	endfunction : out_stage

	always_comb begin
		st_d    = st_q;
		a_par   = (a_shape == ebr_pkg::SHAPE_X9) || (a_shape == ebr_pkg::SHAPE_X18) ||
			(a_shape == ebr_pkg::SHAPE_X36);
		b_par   = (b_shape == ebr_pkg::SHAPE_X9) || (b_shape == ebr_pkg::SHAPE_X18) ||
			(b_shape == ebr_pkg::SHAPE_X36);
		a_wide  = (a_shape == ebr_pkg::SHAPE_X32) || (a_shape == ebr_pkg::SHAPE_X36);
		b_wide  = (b_shape == ebr_pkg::SHAPE_X32) || (b_shape == ebr_pkg::SHAPE_X36);
		sr_wn   = 12'(a_w * sr_taps);
		sr_bits = 20'(sr_wn * sr_len);
		sr_mask = 36'((37'h1 << sr_wn[5:0]) - 37'h1);
		a_re    = a_rd | a_in_clr;
		b_re    = b_rd | b_in_clr;
		case (mode)
			ebr_pkg::MODE_SDP, ebr_pkg::MODE_FIFO: begin
				legal = (a_par == b_par);
			end
			ebr_pkg::MODE_TDP: begin
				legal = (a_par == b_par) && !a_wide && !b_wide;
			end
			ebr_pkg::MODE_SHIFT: begin
				legal = (sr_taps != 6'h00) && (sr_len != 8'h00) && (sr_wn <= `EBR_SR_MAX_WN) &&
					(sr_bits <= `EBR_SR_MAX_BITS) && (sr_len <= `EBR_SR_MAX_LEN);
			end
			ebr_pkg::MODE_ROM: begin
				legal = 1'b1;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
		st_d.err = !legal;

		// write, read and output defaults; an illegal setup writes nothing
		wa_en   = 1'b0;
		wa_row  = a_row;
		wa_bits = a_wmask << a_col;
		wa_data = (a_din & a_wmask) << a_col;
		wb_en   = 1'b0;
		wb_bits = b_wmask << b_col;
		wb_data = (b_din & b_wmask) << b_col;
		ra_row  = a_row;
		a_ld    = 1'b0;
		b_ld    = 1'b0;
		a_val   = (ra_data >> a_col) & a_wmask;
		b_val   = (rb_data >> b_col) & b_wmask;
		a_oreg  = a_out_reg;
		b_oreg  = b_out_reg;

		case (mode)
			ebr_pkg::MODE_SDP, ebr_pkg::MODE_FIFO: begin
				wa_en = legal && a_wr && a_in_ce;
				b_ld  = legal && b_re && b_in_ce;
				if (wa_en && (a_row == b_row) && ((wa_bits & (b_wmask << b_col)) != 36'h0)) begin
					b_val = rdw_old_data ? b_val : `EBR_UNDEF_WORD;
				end
				if (mode == ebr_pkg::MODE_FIFO) begin
					b_oreg = 1'b0;
				end
			end
			ebr_pkg::MODE_TDP: begin
				wa_en = legal && a_wr && a_in_ce;
				wb_en = legal && b_wr && b_in_ce;
				a_ld  = legal && (a_re || a_wr) && a_in_ce;
				b_ld  = legal && (b_re || b_wr) && b_in_ce;
				if (wb_en && (a_row == b_row) && ((wb_bits & (a_wmask << a_col)) != 36'h0)) begin
					a_val = rdw_old_data ? a_val : `EBR_UNDEF_WORD;
				end
				if (wa_en && (a_row == b_row) && ((wa_bits & (b_wmask << b_col)) != 36'h0)) begin
					b_val = rdw_old_data ? b_val : `EBR_UNDEF_WORD;
				end
				if (a_wr) begin
					a_val = a_din & a_wmask;
				end
				if (b_wr) begin
					b_val = b_din & b_wmask;
				end
			end
			ebr_pkg::MODE_SHIFT: begin
				// tap length is capped at the row count; packs taps in one row
				ra_row  = st_q.sr_ptr;
				wa_row  = st_q.sr_ptr;
				wa_en   = legal && a_in_ce;
				wa_bits = sr_mask;
				wa_data = ((ra_data << a_w) | (a_din & a_wmask)) & sr_mask;
				a_ld    = wa_en;
				a_val   = ra_data & sr_mask;
				if (wa_en) begin
					st_d.sr_ptr = (8'(st_q.sr_ptr) + 8'h01 >= sr_len) ?
						7'h00 : 7'(st_q.sr_ptr + 7'h01);
				end
			end
			ebr_pkg::MODE_ROM: begin
				a_ld = a_re && a_in_ce;
			end
			default: begin
				a_ld = 1'b0;
			end
		endcase

		a_stage = out_stage(a_ld, a_val, a_oreg, a_out_ce, a_out_clr, a_in_clr,
			st_q.a_s1, st_q.a_q);
		b_stage = out_stage(b_ld, b_val, b_oreg, b_out_ce, b_out_clr, b_in_clr,
			st_q.b_s1, st_q.b_q);
		st_d.a_s1 = a_stage[2*`EBR_ROW_BITS-1:`EBR_ROW_BITS];
		st_d.a_q  = a_stage[`EBR_ROW_BITS-1:0];
		st_d.b_s1 = b_stage[2*`EBR_ROW_BITS-1:`EBR_ROW_BITS];
		st_d.b_q  = b_stage[`EBR_ROW_BITS-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q.a_s1   <= `EBR_Q_RESET;
			st_q.a_q    <= `EBR_Q_RESET;
			st_q.b_s1   <= `EBR_Q_RESET;
			st_q.b_q    <= `EBR_Q_RESET;
			st_q.sr_ptr <= 7'h00;
			st_q.err    <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign a_q     = st_q.a_q;
	assign b_q     = st_q.b_q;
	assign cfg_err = st_q.err;
endmodule : ebr_block

/* tb/ebr_user.sv */
// Purpose: user logic model on the port side of the block ram
// Assumes: single clock, one request per call
// Notes:   strobes drop at the taking edge so no request repeats
`timescale 1ns/10ps
module ebr_user (
	input  logic		clk_sys,
	output logic [11:0]	a_addr,
	output logic [35:0]	a_din,
	output logic		a_wr,
	output logic		a_rd,
	output logic [11:0]	b_addr,
	output logic [35:0]	b_din,
	output logic		b_wr,
	output logic		b_rd
);
	initial begin
		{a_wr, a_rd, b_wr, b_rd} = 4'h0;
		{a_addr, b_addr} = 24'h0;
		{a_din, b_din} = 72'h0;
	end
	task automatic op(input logic aw, ar, input logic [11:0] aa, input logic [35:0] ad,
		input logic bw, br, input logic [11:0] ba, input logic [35:0] bd);
		@(posedge clk_sys);
		a_wr <= aw;
		a_rd <= ar;
		a_addr <= aa;
		a_din <= ad;
		b_wr <= bw && !(aw && aa == ba);
		b_rd <= br;
		b_addr <= ba;
		b_din <= bd;
		@(posedge clk_sys);
		{a_wr, a_rd, b_wr, b_rd} <= 4'h0;
		// data no longer valid once strobes drop
		a_din <= ~ad;
		b_din <= ~bd;
		#1;
	endtask : op
	task automatic feed(input logic [35:0] d);
		@(posedge clk_sys);
		a_din <= d;
	endtask : feed
endmodule : ebr_user

/* tb/ebr_block_checker.sv */
// Purpose: concurrent checks on the block ram ports
// Assumes: single clock domain
// Notes:   data checks limited to x32 and x16 shapes
`timescale 1ns/10ps
`include "ebr_cfg.svh"
module ebr_block_checker (
	input logic		clk_sys,
	input logic		rst_n,
	input logic		clk_en,
	input ebr_pkg::mode_e	mode,
	input logic		rdw_old_data,
	input ebr_pkg::shape_e	a_shape,
	input ebr_pkg::shape_e	b_shape,
	input logic		a_out_reg,
	input logic		b_out_reg,
	input logic [7:0]	sr_len,
	input logic [11:0]	a_addr,
	input logic [35:0]	a_din,
	input logic		a_wr,
	input logic		a_in_ce,
	input logic		a_out_clr,
	input logic [11:0]	b_addr,
	input logic		b_rd,
	input logic		b_in_ce,
	input logic		b_in_clr,
	input logic		b_out_clr,
	input logic [35:0]	a_q,
	input logic [35:0]	b_q,
	input logic		cfg_err
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic sdp, w32, a_wt, b_rt, b_idle, mix;
	assign sdp = mode == ebr_pkg::MODE_SDP;
	assign w32 = a_shape == ebr_pkg::SHAPE_X32 && b_shape == ebr_pkg::SHAPE_X32;
	assign a_wt = clk_en && a_in_ce && a_wr;
	assign b_rt = clk_en && b_in_ce && b_rd && !b_in_clr && !b_out_reg && !b_out_clr;
	assign b_idle = clk_en && b_in_ce && !b_rd && !b_in_clr && !b_out_reg && !b_out_clr;
	assign mix = (a_shape >= ebr_pkg::SHAPE_X9) != (b_shape >= ebr_pkg::SHAPE_X9);
	sequence s_write;
		sdp && w32 && a_wt;
	endsequence
	sequence s_read_back;
		sdp && w32 && b_rt && !a_wt && b_addr[6:0] == $past(a_addr[6:0], 2);
	endsequence
	chk_power_zero: assert property ($rose(rst_n) |-> a_q == 36'h0 && b_q == 36'h0)
		else $error("outputs not zero after reset");
	chk_idle_hold: assert property (sdp && b_idle |=> $stable(b_q))
		else $error("read output moved without a read");
	chk_write_commit: assert property (s_write ##1 !a_wt ##1 s_read_back
		|=> b_q == {4'h0, $past(a_din[31:0], 3)})
		else $error("written word not read back");
	chk_collide_undef: assert property (s_write and b_rt && !rdw_old_data
		&& b_addr[6:0] == a_addr[6:0] |=> b_q == `EBR_UNDEF_WORD)
		else $error("collision did not give undefined word");
	chk_tdp_pass: assert property (mode == ebr_pkg::MODE_TDP && a_wt
		&& a_shape == ebr_pkg::SHAPE_X16 && b_shape < ebr_pkg::SHAPE_X32
		&& !a_out_reg && !a_out_clr |=> a_q == {20'h0, $past(a_din[15:0])})
		else $error("write data did not pass through");
	chk_tdp_wide: assert property (mode == ebr_pkg::MODE_TDP && clk_en
		&& a_shape inside {ebr_pkg::SHAPE_X32, ebr_pkg::SHAPE_X36} |=> cfg_err)
		else $error("wide dual port shape accepted");
	chk_family_mix: assert property ((sdp || mode == ebr_pkg::MODE_TDP) && clk_en && mix
		|=> cfg_err)
		else $error("mixed shape families accepted");
	chk_sdp_legal: assert property (sdp && clk_en && a_shape < ebr_pkg::SHAPE_X9
		&& b_shape < ebr_pkg::SHAPE_X9 |=> !cfg_err)
		else $error("legal pairing flagged");
	chk_shift_size: assert property (mode == ebr_pkg::MODE_SHIFT && clk_en
		&& sr_len > 8'd128 |=> cfg_err)
		else $error("oversized shift accepted");
endmodule : ebr_block_checker
bind ebr_block ebr_block_checker chk (.*);

/* tb/tb.sv */
// Purpose: self-checking bench of the block ram
// Assumes: user model issues port requests, bench owns the setup
// Notes:   shift latency taken as sr_len accepted inputs
`timescale 1ns/10ps
`include "ebr_cfg.svh"
module tb;
	logic			clk_sys, rst_n, clk_en, rdw_old_data, a_out_reg, b_out_reg, cfg_err;
	logic			a_in_ce, a_out_ce, a_in_clr, a_out_clr, b_in_ce, b_out_ce, b_in_clr, b_out_clr;
	logic			a_wr, a_rd, b_wr, b_rd;
	logic [11:0]		a_addr, b_addr;
	logic [35:0]		a_din, b_din, a_q, b_q;
	logic [7:0]		sr_len;
	logic [5:0]		sr_taps;
	ebr_pkg::mode_e		mode;
	ebr_pkg::shape_e	a_shape, b_shape;
	int			fail_count, compares;
	ebr_block dut (.*);
	ebr_user user (.*);
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic settle;
		@(posedge clk_sys);
		#1;
	endtask : settle
	task automatic t_sdp;
		user.op(1'b1, 1'b0, 12'h000, 36'h044332211, 1'b0, 1'b0, 12'h000, 36'h0);
		// b writes must be ignored, so bytes stay
		for (int k = 0; k < 4; k++) begin
			user.op(k == 0, 1'b0, 12'h001, 36'h0a5a5a5a5, 1'b1, 1'b1, 12'(k), 36'h0ff);
			chk(b_q, 36'(8'(32'h44332211 >> (8 * k))));
		end
		user.op(1'b0, 1'b0, 12'h0, 36'h0, 1'b0, 1'b1, 12'h007, 36'h0);
		chk(b_q, 36'h0000000a5);
	endtask : t_sdp
	task automatic t_rdw;
		@(posedge clk_sys);
		b_shape <= ebr_pkg::SHAPE_X32;
		user.op(1'b1, 1'b0, 12'h0, 36'h012345678, 1'b0, 1'b1, 12'h0, 36'h0);
		chk(b_q, 36'h044332211);
		@(posedge clk_sys);
		rdw_old_data <= 1'b0;
		user.op(1'b1, 1'b0, 12'h0, 36'h0deadbeef, 1'b0, 1'b1, 12'h0, 36'h0);
		chk(b_q, `EBR_UNDEF_WORD);
		user.op(1'b0, 1'b0, 12'h0, 36'h0, 1'b0, 1'b1, 12'h0, 36'h0);
		chk(b_q, 36'h0deadbeef);
	endtask : t_rdw
	task automatic t_hold;
		user.op(1'b1, 1'b0, 12'h0, 36'h011111111, 1'b0, 1'b0, 12'h0, 36'h0);
		repeat (3) settle();
		chk(b_q, 36'h0deadbeef);
		@(posedge clk_sys);
		b_in_clr <= 1'b1;
		@(posedge clk_sys);
		b_in_clr <= 1'b0;
		#1;
		chk(b_q, 36'h011111111);
		@(posedge clk_sys);
		b_out_reg <= 1'b1;
		user.op(1'b0, 1'b0, 12'h0, 36'h0, 1'b0, 1'b1, 12'h001, 36'h0);
		settle();
		chk(b_q, 36'h0a5a5a5a5);
		@(posedge clk_sys);
		b_out_clr <= 1'b1;
		@(posedge clk_sys);
		b_out_clr <= 1'b0;
		#1;
		chk(b_q, 36'h0);
	endtask : t_hold
	task automatic t_rom_fifo;
		@(posedge clk_sys);
		mode <= ebr_pkg::MODE_ROM;
		user.op(1'b1, 1'b1, 12'h0, 36'h0bad0bad0, 1'b0, 1'b0, 12'h0, 36'h0);
		chk(a_q, 36'h011111111);
		user.op(1'b0, 1'b1, 12'h0, 36'h0, 1'b0, 1'b0, 12'h0, 36'h0);
		chk(a_q, 36'h011111111);
		@(posedge clk_sys);
		mode <= ebr_pkg::MODE_FIFO;
		user.op(1'b1, 1'b0, 12'h006, 36'h076543210, 1'b0, 1'b0, 12'h0, 36'h0);
		user.op(1'b0, 1'b0, 12'h0, 36'h0, 1'b0, 1'b1, 12'h006, 36'h0);
		chk(b_q, 36'h076543210);
	endtask : t_rom_fifo
	task automatic t_tdp;
		@(posedge clk_sys);
		mode <= ebr_pkg::MODE_TDP;
		a_shape <= ebr_pkg::SHAPE_X16;
		b_shape <= ebr_pkg::SHAPE_X16;
		b_out_reg <= 1'b0;
		user.op(1'b1, 1'b0, 12'h002, 36'h00000beef, 1'b1, 1'b0, 12'h003, 36'h00000cafe);
		chk(a_q, 36'h00000beef);
		chk(b_q, 36'h00000cafe);
		user.op(1'b0, 1'b1, 12'h003, 36'h0, 1'b0, 1'b1, 12'h002, 36'h0);
		chk(a_q, 36'h00000cafe);
		chk(b_q, 36'h00000beef);
		@(posedge clk_sys);
		b_shape <= ebr_pkg::SHAPE_X8;
		user.op(1'b0, 1'b0, 12'h0, 36'h0, 1'b0, 1'b1, 12'h004, 36'h0);
		chk(b_q, 36'h0000000ef);
		@(posedge clk_sys);
		a_shape <= ebr_pkg::SHAPE_X32;
		settle();
		chk({35'h0, cfg_err}, 36'h1);
		@(posedge clk_sys);
		a_shape <= ebr_pkg::SHAPE_X9;
		settle();
		chk({35'h0, cfg_err}, 36'h1);
		@(posedge clk_sys);
		a_shape <= ebr_pkg::SHAPE_X16;
		settle();
		chk({35'h0, cfg_err}, 36'h0);
	endtask : t_tdp
	task automatic t_shift;
		@(posedge clk_sys);
		mode <= ebr_pkg::MODE_SHIFT;
		a_shape <= ebr_pkg::SHAPE_X8;
		for (int n = 0; n < 24; n++) begin
			user.feed(36'(n));
			#1;
			if (n > 12)
				chk(a_q, 36'({8'(n - 9), 8'(n - 5)}));
		end
		@(posedge clk_sys);
		sr_len <= 8'd200;
		settle();
		chk({35'h0, cfg_err}, 36'h1);
		@(posedge clk_sys);
		sr_len <= 8'h04;
		sr_taps <= 6'h05;
		settle();
		chk({35'h0, cfg_err}, 36'h1);
	endtask : t_shift
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		{a_in_ce, a_out_ce, b_in_ce, b_out_ce} = 4'hf;
		{a_in_clr, a_out_clr, b_in_clr, b_out_clr} = 4'h0;
		{rdw_old_data, a_out_reg, b_out_reg} = 3'h4;
		mode = ebr_pkg::MODE_SDP;
		a_shape = ebr_pkg::SHAPE_X32;
		b_shape = ebr_pkg::SHAPE_X8;
		sr_len = 8'h04;
		sr_taps = 6'h02;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		settle();
		chk(a_q, 36'h0);
		chk(b_q, 36'h0);
		t_sdp();
		t_rdw();
		t_hold();
		t_rom_fifo();
		t_tdp();
		t_shift();
		give_verdict();
	end
	// far beyond the ninety-odd cycles the tests need
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
endmodule : tb
